// ### pkg/uelc_pkg.sv
// Constants shared by the serial-port event, FIFO control and line format block
package uelc_pkg;
    localparam logic [7:0] OFF_EVENT_FIFO  = 8'h08;
    localparam logic [7:0] OFF_LINE_BANK   = 8'h0c;
    localparam logic [7:0] OFF_LINE_SHADOW = 8'h10;
    localparam logic [7:0] OFF_EXT_CONFIG  = 8'h14;
    localparam int         FC_FIFO_EN      = 0;
    localparam int         FC_RX_RESET     = 1;
    localparam int         FC_TX_RESET     = 2;
    localparam int         FC_TX_TH_LO     = 4;
    localparam int         FC_RX_TH_LO     = 6;
    localparam int         LF_STOP         = 2;
    localparam int         LF_PARITY_ON    = 3;
    localparam int         LF_EVEN         = 4;
    localparam int         LF_STICK        = 5;
    localparam int         LF_BREAK        = 6;
    localparam int         LF_BANK_WRITE   = 7;
    localparam int         EV_RX_HIGH      = 0;
    localparam int         EV_TX_LOW       = 1;
    localparam int         EV_LINE_ERR     = 2;
    localparam int         EV_MODEM        = 3;
    localparam int         EV_TX_EMPTY     = 5;
    localparam int         XC_EXT_SELECT   = 0;
    localparam logic [7:0] EV_USED_MASK    = 8'h2f;
    localparam logic [7:0] LINE_RESET      = 8'h00;
    localparam logic [7:0] BANK_RESET      = 8'h00;
    localparam logic [7:0] BANK2_CODE      = 8'he0;
    localparam logic [7:0] BANK3_CODE      = 8'he4;
    localparam logic [4:0] TX_TH_0         = 5'h01;
    localparam logic [4:0] TX_TH_1         = 5'h03;
    localparam logic [4:0] TX_TH_2         = 5'h09;
    localparam logic [4:0] TX_TH_3         = 5'h0d;
    localparam logic [4:0] RX_TH_0         = 5'h01;
    localparam logic [4:0] RX_TH_1         = 5'h04;
    localparam logic [4:0] RX_TH_2         = 5'h08;
    localparam logic [4:0] RX_TH_3         = 5'h0e;
    localparam logic [3:0] LEG_NONE        = 4'h1;
    localparam logic [3:0] LEG_LINE        = 4'h6;
    localparam logic [3:0] LEG_RX          = 4'h4;
    localparam logic [3:0] LEG_RX_TIMEOUT  = 4'hc;
    localparam logic [3:0] LEG_TX          = 4'h2;
    localparam logic [3:0] LEG_MODEM       = 4'h0;
    localparam logic [1:0] RESP_OKAY       = 2'h0;
    localparam logic [1:0] RESP_SLVERR     = 2'h2;
endpackage : uelc_pkg

// ### rtl/uelc_bank_decode.sv
// Bank number decode for a write to the shared line/bank address
`timescale 1ns/10ps
module uelc_bank_decode
    import uelc_pkg::*;
(
    input  wire logic [7:0] code_in,
    output logic [1:0]      bank_out,
    output logic            known_out,
    output logic            line_write_out
);
    always_comb
    begin
        known_out = 1'b1;
        if (!code_in[7])
            bank_out = 2'h0; // RL20
        else if (!code_in[6] || code_in[1] || code_in[0])
            bank_out = 2'h1; // RL20
        else if (code_in == BANK2_CODE)
            bank_out = 2'h2; // RL20
        else if (code_in == BANK3_CODE)
            bank_out = 2'h3; // RL20
        else
        begin
            bank_out  = 2'h0;
            known_out = 1'b0;
        end
        line_write_out = !code_in[LF_BANK_WRITE]; // RL13
    end
endmodule : uelc_bank_decode

// ### rtl/uelc_level_flags.sv
// Receive high-level and transmit low-level event decode
`timescale 1ns/10ps
module uelc_level_flags
    import uelc_pkg::*;
#(
    parameter int LEVEL_W = 5
)(
    input  wire logic               fifo_en_in,
    input  wire logic               extended_in,
    input  wire logic [1:0]         tx_th_field_in,
    input  wire logic [1:0]         rx_th_field_in,
    input  wire logic [LEVEL_W-1:0] rx_level_in,
    input  wire logic [LEVEL_W-1:0] tx_level_in,
    input  wire logic               rx_holding_full_in,
    input  wire logic               rx_timeout_in,
    input  wire logic               tx_holding_empty_in,
    output logic                    rx_high_out,
    output logic                    tx_low_out
);
    function automatic logic [4:0] uelc_tx_th(input logic [1:0] f);
        case (f)
            2'h0:    uelc_tx_th = TX_TH_0;
            2'h1:    uelc_tx_th = TX_TH_1;
            2'h2:    uelc_tx_th = TX_TH_2;
            default: uelc_tx_th = TX_TH_3;
        endcase
    endfunction : uelc_tx_th

    function automatic logic [4:0] uelc_rx_th(input logic [1:0] f);
        case (f)
            2'h0:    uelc_rx_th = RX_TH_0;
            2'h1:    uelc_rx_th = RX_TH_1;
            2'h2:    uelc_rx_th = RX_TH_2;
            default: uelc_rx_th = RX_TH_3;
        endcase
    endfunction : uelc_rx_th

    always_comb
    begin
        if (!fifo_en_in)
        begin
            rx_high_out = rx_holding_full_in; // RL2
            tx_low_out  = tx_holding_empty_in; // RL3
        end
        else
        begin
            rx_high_out = (32'(rx_level_in) >= 32'(uelc_rx_th(rx_th_field_in))) || rx_timeout_in; // RL11
            // Outside extended mode the threshold field is ignored: low means empty
            if (extended_in)
                tx_low_out = 32'(tx_level_in) < 32'(uelc_tx_th(tx_th_field_in)); // RL10
            else
                tx_low_out = (tx_level_in == '0);
        end
    end
endmodule : uelc_level_flags

// ### rtl/uelc_regs.sv
// Event flags, FIFO control, line format and bank select registers behind AXI4-Lite
`timescale 1ns/10ps
// Notes on behaviour
// RL1 - Extended mode: one pending bit per source
// RL2 - Bit 0: receive data at or above level
// RL3 - Bit 1: transmit data below level
// RL4 - Bit 2: receive error or break seen
// RL5 - Bit 3: any low modem status bit
// RL6 - Bit 5 mirrors transmitter fully empty
// RL7 - FIFO control write-only; bit 0 enables
// RL8 - Bit 1 pulses receiver soft reset
// RL9 - Bit 2 pulses transmitter soft reset
// RL10 - Transmit threshold 1/3/9/13, extended only
// RL11 - Receive threshold 1/4/8/14, at or above
// RL12 - Shared address reads bank select
// RL13 - Bit 7 set protects line format
// RL14 - Reset clears line format and bank
// RL15 - Bits 1:0 give five to eight bits
// RL16 - Bit 2 adds stop time, receiver one
// RL17 - Parity enable, even select, stick parity
// RL18 - Break holds serial output low
// RL19 - Host waits for empty around break
// RL20 - Bank decode table, line only bank 0
// RL21 - Extended select bit chooses flag layout
// RL22 - Reserved bits read zero, ignore writes
module uelc_regs
    import uelc_pkg::*;
#(
    parameter int LEVEL_W = 5
)(
    input  wire logic               sys_clk_in,
    input  wire logic               rst_in,
    input  wire logic               s_axi_awvalid_in,
    output logic                    s_axi_awready_out,
    input  wire logic [7:0]         s_axi_awaddr_in,
    input  wire logic               s_axi_wvalid_in,
    output logic                    s_axi_wready_out,
    input  wire logic [31:0]        s_axi_wdata_in,
    input  wire logic [3:0]         s_axi_wstrb_in,
    output logic                    s_axi_bvalid_out,
    input  wire logic               s_axi_bready_in,
    output logic [1:0]              s_axi_bresp_out,
    input  wire logic               s_axi_arvalid_in,
    output logic                    s_axi_arready_out,
    input  wire logic [7:0]         s_axi_araddr_in,
    output logic                    s_axi_rvalid_out,
    input  wire logic               s_axi_rready_in,
    output logic [31:0]             s_axi_rdata_out,
    output logic [1:0]              s_axi_rresp_out,
    input  wire logic [LEVEL_W-1:0] rx_level_in,
    input  wire logic [LEVEL_W-1:0] tx_level_in,
    input  wire logic               rx_holding_full_in,
    input  wire logic               rx_timeout_in,
    input  wire logic               tx_holding_empty_in,
    input  wire logic               transmitter_fully_empty_in,
    input  wire logic               overrun_in,
    input  wire logic [2:0]         rx_char_err_in,
    input  wire logic [2:0]         rx_bottom_err_in,
    input  wire logic               line_status_read_in,
    input  wire logic [3:0]         modem_status_low_in,
    input  wire logic               tx_line_in,
    output logic                    serial_out_pin_out,
    output logic                    fifo_enable_out,
    output logic                    fifo_flush_out,
    output logic                    rx_soft_reset_out,
    output logic                    tx_soft_reset_out,
    output logic [1:0]              char_length_field_out,
    output logic                    stop_bit_count_out,
    output logic                    parity_on_out,
    output logic                    even_parity_choice_out,
    output logic                    forced_parity_out,
    output logic [1:0]              bank_out,
    output logic                    extended_select_out
);
    import uelc_pkg::*;

    logic [7:0]  aw_addr;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        aw_full;
    logic        w_full;
    logic        wr_fire;
    logic [7:0]  line_format_control;
    logic [7:0]  register_bank_select;
    logic [7:0]  extended_config_one;
    logic [1:0]  tx_threshold_field;
    logic [1:0]  rx_threshold_field;
    logic [7:0]  event_flags_extended;
    logic        line_error_flag;
    logic        rx_high_level_flag;
    logic        tx_low_level_flag;
    logic        line_error_set;
    logic [1:0]  dec_bank;
    logic        dec_known;
    logic        dec_line_write;
    logic [31:0] next_rdata;
    logic        next_rerr;
    logic [3:0]  legacy_code;
    logic        wr_event_fifo;
    logic        wr_line_bank;

    assign wr_fire       = aw_full && w_full && !s_axi_bvalid_out;
    assign wr_event_fifo = wr_fire && w_lane0 && aw_addr == OFF_EVENT_FIFO;
    assign wr_line_bank  = wr_fire && w_lane0 && aw_addr == OFF_LINE_BANK;

    uelc_level_flags #(
        .LEVEL_W             (LEVEL_W)
    ) u_levels (
        .fifo_en_in          (fifo_enable_out),
        .extended_in         (extended_select_out),
        .tx_th_field_in      (tx_threshold_field),
        .rx_th_field_in      (rx_threshold_field),
        .rx_level_in         (rx_level_in),
        .tx_level_in         (tx_level_in),
        .rx_holding_full_in  (rx_holding_full_in),
        .rx_timeout_in       (rx_timeout_in),
        .tx_holding_empty_in (tx_holding_empty_in),
        .rx_high_out         (rx_high_level_flag),
        .tx_low_out          (tx_low_level_flag)
    );

    uelc_bank_decode u_bank (
        .code_in        (w_data),
        .bank_out       (dec_bank),
        .known_out      (dec_known),
        .line_write_out (dec_line_write)
    );

    // Write channel: address and data taken in either order, answer after both
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            s_axi_awready_out <= 1'b1;
            s_axi_wready_out  <= 1'b1;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= RESP_OKAY;
            aw_full           <= 1'b0;
            w_full            <= 1'b0;
            aw_addr           <= 8'h00;
            w_data            <= 8'h00;
            w_lane0           <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid_in && s_axi_awready_out)
            begin
                aw_full           <= 1'b1;
                aw_addr           <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out)
            begin
                w_full           <= 1'b1;
                w_data           <= s_axi_wdata_in[7:0];
                w_lane0          <= s_axi_wstrb_in[0];
                s_axi_wready_out <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_full          <= 1'b0;
                w_full           <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                case (aw_addr)
                    OFF_EVENT_FIFO, OFF_LINE_BANK, OFF_EXT_CONFIG: s_axi_bresp_out <= RESP_OKAY;
                    default:                                      s_axi_bresp_out <= RESP_SLVERR;
                endcase
            end
            if (s_axi_bvalid_out && s_axi_bready_in)
            begin
                s_axi_bvalid_out  <= 1'b0;
                s_axi_awready_out <= 1'b1;
                s_axi_wready_out  <= 1'b1;
            end
        end
    end

    // FIFO control storage reads back only as the enable, in bits 7:6 of the legacy flag layout
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            fifo_enable_out    <= 1'b0;
            fifo_flush_out     <= 1'b0;
            rx_soft_reset_out  <= 1'b0;
            tx_soft_reset_out  <= 1'b0;
            tx_threshold_field <= 2'h0;
            rx_threshold_field <= 2'h0;
        end
        else
        begin
            fifo_flush_out    <= wr_event_fifo && !w_data[FC_FIFO_EN]; // RL7
            rx_soft_reset_out <= wr_event_fifo && w_data[FC_RX_RESET]; // RL8
            tx_soft_reset_out <= wr_event_fifo && w_data[FC_TX_RESET]; // RL9
            if (wr_event_fifo)
            begin
                fifo_enable_out    <= w_data[FC_FIFO_EN]; // RL7
                tx_threshold_field <= w_data[FC_TX_TH_LO +: 2]; // RL10
                rx_threshold_field <= w_data[FC_RX_TH_LO +: 2]; // RL11
            end
        end
    end

    // Bit 7 guards the format so bank switching cannot corrupt it
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            line_format_control  <= LINE_RESET; // RL14
            register_bank_select <= BANK_RESET; // RL14
            bank_out             <= 2'h0;
        end
        else if (wr_line_bank)
        begin
            register_bank_select <= w_data; // RL13
            if (dec_known)
                bank_out <= dec_bank; // RL20
            if (dec_line_write)
                line_format_control <= w_data; // RL13
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            extended_config_one <= 8'h00;
        else if (wr_fire && w_lane0 && aw_addr == OFF_EXT_CONFIG)
            extended_config_one <= {7'h00, w_data[XC_EXT_SELECT]}; // RL22
    end

    assign extended_select_out    = extended_config_one[XC_EXT_SELECT]; // RL21
    assign char_length_field_out  = line_format_control[1:0]; // RL15
    assign stop_bit_count_out     = line_format_control[LF_STOP]; // RL16
    assign parity_on_out          = line_format_control[LF_PARITY_ON]; // RL17
    assign even_parity_choice_out = line_format_control[LF_EVEN]; // RL17
    assign forced_parity_out      = line_format_control[LF_STICK]; // RL17

    // Break only gates the line; the transmitter still times characters
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            serial_out_pin_out <= 1'b1;
        else
            serial_out_pin_out <= tx_line_in && !line_format_control[LF_BREAK]; // RL18
    end

    // With the FIFO enabled, parity, framing and break wait for the bottom of the FIFO; with it off they set at once
    assign line_error_set = overrun_in || (fifo_enable_out ? |rx_bottom_err_in : |rx_char_err_in); // RL4

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            line_error_flag <= 1'b0;
        else if (line_error_set)
            line_error_flag <= 1'b1; // RL4
        else if (line_status_read_in || rx_soft_reset_out)
            line_error_flag <= 1'b0;
    end

    // Flags ignore the interrupt enables entirely
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            event_flags_extended <= 8'h00;
        else
        begin
            event_flags_extended              <= 8'h00; // RL22
            event_flags_extended[EV_RX_HIGH]  <= rx_high_level_flag; // RL1
            event_flags_extended[EV_TX_LOW]   <= tx_low_level_flag; // RL1
            event_flags_extended[EV_LINE_ERR] <= line_error_flag || line_error_set; // RL4
            event_flags_extended[EV_MODEM]    <= |modem_status_low_in; // RL5
            event_flags_extended[EV_TX_EMPTY] <= transmitter_fully_empty_in; // RL6
        end
    end

    always_comb
    begin
        if (event_flags_extended[EV_LINE_ERR])
            legacy_code = LEG_LINE;
        else if (rx_timeout_in && fifo_enable_out)
            legacy_code = LEG_RX_TIMEOUT;
        else if (event_flags_extended[EV_RX_HIGH])
            legacy_code = LEG_RX;
        else if (event_flags_extended[EV_TX_LOW])
            legacy_code = LEG_TX;
        else if (event_flags_extended[EV_MODEM])
            legacy_code = LEG_MODEM;
        else
            legacy_code = LEG_NONE;
    end

    always_comb
    begin
        next_rdata = 32'h0000_0000;
        next_rerr  = 1'b0;
        case (s_axi_araddr_in)
            OFF_EVENT_FIFO:
            begin
                if (extended_select_out)
                    next_rdata[7:0] = event_flags_extended & EV_USED_MASK; // RL1
                else
                    next_rdata[7:0] = {fifo_enable_out, fifo_enable_out, 2'h0, legacy_code}; // RL21
            end
            OFF_LINE_BANK:   next_rdata[7:0] = register_bank_select; // RL12
            OFF_LINE_SHADOW: next_rdata[7:0] = line_format_control; // RL12
            OFF_EXT_CONFIG:  next_rdata[7:0] = extended_config_one;
            default:         next_rerr = 1'b1;
        endcase
    end

    // Data is captured when the address is taken, so rdata holds while waiting
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            s_axi_arready_out <= 1'b1;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= RESP_OKAY;
        end
        else if (s_axi_arvalid_in && s_axi_arready_out)
        begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rdata_out   <= next_rdata;
            s_axi_rresp_out   <= next_rerr ? RESP_SLVERR : RESP_OKAY;
        end
        else if (s_axi_rvalid_out && s_axi_rready_in)
        begin
            s_axi_rvalid_out  <= 1'b0;
            s_axi_arready_out <= 1'b1;
        end
    end

    sequence s_line_write_open;
        wr_line_bank && !w_data[LF_BANK_WRITE];
    endsequence
    sequence s_line_write_guarded;
        wr_line_bank && w_data[LF_BANK_WRITE];
    endsequence

    a_break_low_out: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RL18
        line_format_control[LF_BREAK] |=> !serial_out_pin_out)
        else $error("serial output not low during break");
    a_line_open_load: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RL13
        s_line_write_open |=> line_format_control == $past(w_data))
        else $error("line format not loaded with bit 7 clear");
    a_line_guard_hold: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RL13
        s_line_write_guarded |=> $stable(line_format_control) && register_bank_select == $past(w_data))
        else $error("line format changed with bit 7 set");
    a_rx_reset_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RL8
        wr_event_fifo && w_data[FC_RX_RESET] |=> rx_soft_reset_out ##1 !rx_soft_reset_out)
        else $error("receiver soft reset not a single pulse");
    a_tx_reset_pulse: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RL9
        tx_soft_reset_out |-> $past(wr_event_fifo) && !$past(tx_soft_reset_out))
        else $error("transmitter soft reset without a write");
    a_line_err_sticky: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RL4
        overrun_in ##1 (!line_status_read_in && !rx_soft_reset_out)[*2] |-> event_flags_extended[EV_LINE_ERR])
        else $error("line error flag lost before clear");
    a_empty_mirror: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RL6
        ##1 event_flags_extended[EV_TX_EMPTY] == $past(transmitter_fully_empty_in))
        else $error("transmitter empty flag does not follow");
    a_modem_flag: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RL5
        modem_status_low_in != 4'h0 |=> event_flags_extended[EV_MODEM])
        else $error("modem flag missing");
    a_reserved_zero: assert property (@(posedge sys_clk_in) disable iff (rst_in) // RL22
        (event_flags_extended & ~EV_USED_MASK) == 8'h00)
        else $error("reserved flag bit set");
    a_write_answer: assert property (@(posedge sys_clk_in) disable iff (rst_in)
        aw_full && w_full && !s_axi_bvalid_out |=> s_axi_bvalid_out ##0 !s_axi_awready_out)
        else $error("write response missing");
endmodule : uelc_regs

// ### testbench/tb_top.sv
// Register, event flag, soft reset and break tests for the line control block
`timescale 1ns/10ps
module tb_top;
    import uelc_pkg::*;
    logic sys_clk = 0, rst = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, ovr = 0, line_status_reg = 0, hf = 0, rto = 0, hte = 0;
    logic [7:0] aa = 0, ara = 0, sh = 0;
    logic [31:0] wd = 0, rd, d;
    logic [4:0] rxlv = 0, txlv = 0;
    logic [3:0] mdm = 0;
    logic [1:0] br, rr, r, cl, bank;
    logic awr, wr, bv, arr, rv, txl, fe, sop, fen, ffl, rxs, txs, stb, pon, evn, frc, ext, prev;
    int bad_count = 0, compares = 0, rxp = 0, txp = 0, flp = 0;
    logic [15:0] bt [9] = '{16'h3b00, 16'h8001, 16'h0600, 16'hc201, 16'h1500, 16'hc101, 16'he002, 16'he403, 16'hc403};
    logic [31:0] et [7] = '{32'h41040023, 32'h41030120, 32'hb1080c23, 32'hb1070d20,
                            32'hd10e0223, 32'h11010223, 32'ha1080921};
    always #20 sys_clk = ~sys_clk;
    uelc_line_partner far_u (.sys_clk_in(sys_clk), .rst_in(rst), .tx_line_out(txl), .fully_empty_out(fe));
    uelc_regs dut_u (
        .sys_clk_in(sys_clk), .rst_in(rst), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
        .s_axi_awaddr_in(aa), .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_wdata_in(wd),
        .s_axi_wstrb_in(4'h1), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_bresp_out(br),
        .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_araddr_in(ara), .s_axi_rvalid_out(rv),
        .s_axi_rready_in(rre), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr), .rx_level_in(rxlv),
        .tx_level_in(txlv), .rx_holding_full_in(hf), .rx_timeout_in(rto), .tx_holding_empty_in(hte),
        .transmitter_fully_empty_in(fe), .overrun_in(ovr), .rx_char_err_in(3'h0), .rx_bottom_err_in(3'h0),
        .line_status_read_in(line_status_reg), .modem_status_low_in(mdm), .tx_line_in(txl), .serial_out_pin_out(sop),
        .fifo_enable_out(fen), .fifo_flush_out(ffl), .rx_soft_reset_out(rxs), .tx_soft_reset_out(txs),
        .char_length_field_out(cl), .stop_bit_count_out(stb), .parity_on_out(pon),
        .even_parity_choice_out(evn), .forced_parity_out(frc), .bank_out(bank), .extended_select_out(ext));
    // One-cycle pulses are counted so a stuck or doubled pulse shows
    always @(posedge sys_clk)
    begin
        rxp <= rxp + (rxs === 1'b1);
        txp <= txp + (txs === 1'b1);
        flp <= flp + (ffl === 1'b1);
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
        aa <= a;
        wd <= {24'h0, v};
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
        end
        while (bv !== 1'b1);
        resp = br;
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        ara <= a;
        arv <= 1'b1;
        rre <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            if (arr) arv <= 1'b0;
        end
        while (rv !== 1'b1);
        v = rd;
        resp = rr;
    endtask : rd_reg
    task automatic test_done;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (20000) @(posedge sys_clk);
        bad_count++;
        test_done();
    end
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rd_reg(OFF_LINE_SHADOW, d, r);
        chk("line_reset", d, 32'h0);
        for (int i = 0; i < 9; i++)
        begin
            wr_reg(OFF_LINE_BANK, bt[i][15:8], r);
            if (!bt[i][15]) sh = bt[i][15:8];
            chk("bank_out", bank, bt[i][1:0]);
            chk("line_fmt", {frc, evn, pon, stb, cl}, sh[5:0]);
            rd_reg(OFF_LINE_BANK, d, r);
            chk("bank_read", d, {24'h0, bt[i][15:8]});
            rd_reg(OFF_LINE_SHADOW, d, r);
            chk("shadow", d, {24'h0, sh});
        end
        $display("test bank done");
        wr_reg(OFF_LINE_BANK, 8'h40, r);
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge sys_clk);
            chk("break_low", sop, 32'h0);
        end
        wr_reg(OFF_LINE_BANK, 8'h00, r);
        repeat (2) @(posedge sys_clk);
        for (int i = 0; i < 3; i++)
        begin
            prev = txl;
            @(posedge sys_clk);
            chk("serial_out_pin_follow", sop, prev);
        end
        $display("test break done");
        wr_reg(OFF_EXT_CONFIG, 8'h01, r);
        chk("ext_sel", ext, 32'h1);
        for (int i = 0; i < 7; i++)
        begin
            rxlv <= et[i][20:16];
            txlv <= et[i][12:8];
            wr_reg(OFF_EVENT_FIFO, et[i][31:24], r);
            chk("fifo_en", fen, 32'h1);
            rd_reg(OFF_EVENT_FIFO, d, r);
            chk("event_lvl", d, {24'h0, et[i][7:0]});
        end
        mdm <= 4'h8;
        ovr <= 1'b1;
        rto <= 1'b1;
        rxlv <= 5'h00;
        @(posedge sys_clk);
        ovr <= 1'b0;
        rd_reg(OFF_EVENT_FIFO, d, r);
        chk("event_err", d, 32'h2d);
        line_status_reg <= 1'b1;
        @(posedge sys_clk);
        line_status_reg <= 1'b0;
        $display("test events done");
        wr_reg(OFF_EVENT_FIFO, 8'h06, r);
        hf <= 1'b1;
        hte <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("rx_reset", rxp, 32'h1);
        chk("tx_reset", txp, 32'h1);
        chk("flush", flp, 32'h1);
        rd_reg(OFF_EVENT_FIFO, d, r);
        chk("event_nofifo", d, 32'h2b);
        wr_reg(OFF_EXT_CONFIG, 8'h00, r);
        rd_reg(OFF_EVENT_FIFO, d, r);
        chk("event_legacy", d, {24'h0, 4'h0, LEG_RX});
        $display("test soft reset done");
        rd_reg(8'h20, d, r);
        chk("unmapped_rd", r, RESP_SLVERR);
        chk("unmapped_data", d, 32'h0);
        wr_reg(OFF_LINE_SHADOW, 8'h3f, r);
        chk("shadow_wr", r, RESP_SLVERR);
        $display("test map done");
        test_done();
    end
endmodule : tb_top

// ### testbench/uelc_line_partner.sv
// Far-side transmitter model: live serial data and empty status
`timescale 1ns/10ps
module uelc_line_partner (
    input  wire logic sys_clk_in,
    input  wire logic rst_in,
    output logic      tx_line_out,
    output logic      fully_empty_out
);
    // Data toggles every cycle so a forced break low cannot hide behind idle ones
    always_ff @(posedge sys_clk_in)
    begin
        tx_line_out <= rst_in ? 1'b1 : ~tx_line_out;
    end
    // Idle transmitter, so the host may set and clear break at any time
    always_ff @(posedge sys_clk_in)
    begin
        fully_empty_out <= ~rst_in;
    end
endmodule : uelc_line_partner
